/* ors_cfg.svh */
// Purpose: Offsets, field positions, reset values and codes of the OAM maintenance register group
// Assumes: Included by bare name; definitions only
// Notes: Offsets are register indices; the APB byte address is four times the index
`ifndef ORS_CFG_SVH
`define ORS_CFG_SVH

// Register indices
`define ORS_IDX_CLR_CTL 8'h44
`define ORS_IDX_RCMD1 8'h4A
`define ORS_IDX_RCMD2 8'h4B
`define ORS_IDX_RCMD3 8'h4C
`define ORS_IDX_TX_CNT 8'h4D
`define ORS_IDX_RX_CNT 8'h4E
`define ORS_IDX_SHADOW 8'h4F

// First remote command register fields
`define ORS_MODE_LSB 0
`define ORS_MODE_MSB 1
`define ORS_OPC_LSB 2
`define ORS_OPC_MSB 3
`define ORS_RCMD1_RST 8'h22
`define ORS_RCMD1_WMASK 8'hCF
`define ORS_MODE_NORMAL 2'h0
`define ORS_MODE_EXTENDED 2'h2

// Reset values and codes
`define ORS_BYTE_RST 8'h00
`define ORS_CNT_CLR_VALUE 8'h00
`define ORS_SHADOW_RST 8'h00
`define ORS_SHADOW_DEF_TERMINAL 8'h07
`define ORS_SHADOW_DEF_CENTER 8'h47
`define ORS_INIT_STAGES 3

`endif

/* ors_far_end.sv */
// Purpose: Far-end media converter seen over the optical link
// Assumes: Driven from the bench through its tasks, all on clk
// Notes: Check lines toggle between packets, so after an all-good packet a stale all-good value recurs every other cycle
`timescale 1ns/1ps
`default_nettype none

module ors_far_end (
    input wire logic clk, // Register clock
    output logic link_up, // Optical link state
    output logic [7:0] status, // Partner status value
    output logic rx_done, // Packet received pulse
    output logic [2:0] goods // CRC, opcode and direction checks
);
    logic busy = 1'b0;
    initial
    begin
        link_up = 1'b0;
        status = 8'hA0;
        rx_done = 1'b0;
        goods = 3'h5;
    end
    always @(posedge clk)
    begin
        if (!busy)
        begin
            goods <= ~goods;
        end
    end
    task automatic send(input logic [2:0] g);
        busy = 1'b1;
        @(posedge clk);
        rx_done <= 1'b1;
        goods <= g;
        @(posedge clk);
        rx_done <= 1'b0;
        busy = 1'b0;
    endtask
    task automatic set_link(input logic up, input logic [7:0] st);
        @(posedge clk);
        link_up <= up;
        status <= st;
    endtask
endmodule // ors_far_end

`default_nettype wire

/* ors_pkg.sv */
// Purpose: Types shared by the OAM maintenance register group
// Assumes: Constants live in ors_cfg.svh
// Notes: Opcode enum order matches the two-bit operating code encoding
package ors_pkg;

    typedef enum logic [1:0] {
        ors_op_read_reply,
        ors_op_read_request,
        ors_op_write_reply,
        ors_op_write_request
    } ors_opcode_t;

    typedef enum logic [1:0] {
        shd_boot,
        shd_mirror,
        shd_retain,
        shd_hold
    } ors_shd_state_t;

endpackage

/* ors_pkt_counter.sv */
// Purpose: Wrapping count of valid maintenance packets
// Assumes: inc and clr come from logic on the same clock
// Notes: An event in the clearing cycle is counted, so the count becomes one
`timescale 1ns/1ps
`default_nettype none
`include "ors_cfg.svh"

module ors_pkt_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clk,                 // Register clock
    input wire logic rst_n,               // Asynchronous reset, active low
    input wire logic inc,                 // Valid packet seen, one-cycle pulse
    input wire logic clr,                 // Software clear, one-cycle pulse
    output logic [WIDTH-1:0] count        // Current count
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    // Natural binary wrap from all ones to zero
    assign count_d = clr ? WIDTH'(inc) : (inc ? count_q + WIDTH'(1) : count_q);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            count_q <= '0;
        else
            count_q <= count_d;
    end

    assign count = count_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cnt_wrap;
        (count_q == {WIDTH{1'b1}}) && inc && !clr |=> count_q == '0;
    endproperty
    a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter did not wrap to zero");

    property p_cnt_hold;
        !inc && !clr |=> count_q == $past(count_q);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved without an event");

endmodule // ors_pkt_counter
`default_nettype wire

/* ors_regs.sv */
// Purpose: APB register group for remote command data, maintenance packet counters and partner status copy
// Assumes: Framing logic runs on pclk; mode straps and link, warm reset and power down arrive as pins
// Notes: One wait-free access phase; prdata, pready and pslverr come from flip-flops loaded in setup
`timescale 1ns/1ps
`default_nettype none
`include "ors_cfg.svh"

// Function
// - Central side extended mode frame data byte from register
// - Extended mode uses full data byte register on central side only
// - Count each valid maintenance packet sent
// - Sent count is 8-bit binary from zero
// - Writing zero to clear control clears counters
// - Count received packets with good CRC, opcode, direction
// - Received count is 8-bit, resets to zero
// - Customer side copy mirrors partner while linked
// - Central side copy mirrors partner after power-on
// - Central side warm reset keeps the copy
// - Retained copy readable at link return, then mirrors
// - Mode field: 00 normal, 10 extended
// - Opcode field selects read/write reply/request
// - Address byte register supplies frame address bits in central side extended mode
module ors_regs #(
    parameter int AW = 12,
    parameter int CNT_W = 8
) (
    input wire logic pclk,                // APB clock, 50 MHz
    input wire logic presetn,             // Power-on reset, active low
    input wire logic psel,                // APB select
    input wire logic penable,             // APB access phase
    input wire logic pwrite,              // APB write
    input wire logic [AW-1:0] paddr,      // APB byte address
    input wire logic [31:0] pwdata,       // APB write data
    input wire logic [3:0] pstrb,         // APB byte strobes
    output logic [31:0] prdata,           // APB read data
    output logic pready,                  // APB ready
    output logic pslverr,                 // APB error on unmapped address
    input wire logic side_strap_pin,      // High selects central office side
    input wire logic optical_link_pin,    // Optical link up
    input wire logic warm_reset_pin,      // Warm reset, active high
    input wire logic power_down_pin,      // Chip power down, active high
    input wire logic [7:0] partner_status, // Partner status register value
    input wire logic [7:0] model_info_data, // Model info data byte
    input wire logic [7:0] model_info_addr, // Model info address byte
    input wire logic cmd_issue,           // Remote command or frame build, pulse
    input wire logic tx_pkt_valid,        // Valid maintenance packet sent, pulse
    input wire logic rx_pkt_done,         // Maintenance packet received, pulse
    input wire logic rx_crc_good,         // Received packet CRC good
    input wire logic rx_opcode_good,      // Received packet opcode valid
    input wire logic rx_dir_good,         // Received packet direction valid
    output logic frame_load,              // Frame bytes updated, pulse
    output logic [7:0] frame_data_byte_bits, // Frame data byte
    output logic [7:0] frame_address_byte, // Frame address byte
    output logic [1:0] frame_opcode,      // Frame operating code
    output logic frame_extended,          // Frame built in extended mode
    output logic central_office_side_mode // Captured side strap
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and strap capture

    localparam int NPIN = 4;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] sync1_q;
    logic [NPIN-1:0] sync2_q;
    logic [`ORS_INIT_STAGES-1:0] start_q;
    logic side_q;
    logic init_pulse;
    logic optical_link;
    logic warm_event;

    assign pin_raw = {power_down_pin, warm_reset_pin, optical_link_pin, side_strap_pin};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_sync
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    sync1_q[gi] <= 1'b0;
                    sync2_q[gi] <= 1'b0;
                end
                else
                begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                end
            end
        end
    endgenerate

    // Strap is taken only once the synchroniser has filled after release
    assign init_pulse = start_q[`ORS_INIT_STAGES-2] & ~start_q[`ORS_INIT_STAGES-1];
    assign optical_link = sync2_q[1];
    assign warm_event = sync2_q[2] | sync2_q[3];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_q <= '0;
            side_q <= 1'b0;
        end
        else
        begin
            start_q <= {start_q[`ORS_INIT_STAGES-2:0], 1'b1};
            if (init_pulse)
                side_q <= sync2_q[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    function automatic logic ors_hit(input logic [AW-1:0] a, input logic [7:0] idx);
        return a == AW'({idx, 2'b00});
    endfunction

    logic hit_clr;
    logic hit_rcmd1;
    logic hit_rcmd2;
    logic hit_rcmd3;
    logic hit_tx;
    logic hit_rx;
    logic hit_shadow;
    logic mapped;
    logic setup_ph;
    logic access_done;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    assign hit_clr = ors_hit(paddr, `ORS_IDX_CLR_CTL);
    assign hit_rcmd1 = ors_hit(paddr, `ORS_IDX_RCMD1);
    assign hit_rcmd2 = ors_hit(paddr, `ORS_IDX_RCMD2);
    assign hit_rcmd3 = ors_hit(paddr, `ORS_IDX_RCMD3);
    assign hit_tx = ors_hit(paddr, `ORS_IDX_TX_CNT);
    assign hit_rx = ors_hit(paddr, `ORS_IDX_RX_CNT);
    assign hit_shadow = ors_hit(paddr, `ORS_IDX_SHADOW);
    assign mapped = hit_clr | hit_rcmd1 | hit_rcmd2 | hit_rcmd3 | hit_tx | hit_rx | hit_shadow;
    assign setup_ph = psel & ~penable;
    assign access_done = psel & penable & pready_q;
    // Error answers still complete, but change no state
    assign wr_en = access_done & pwrite & pstrb[0] & mapped;

    logic [7:0] rcmd1_q;
    logic [7:0] rcmd2_q;
    logic [7:0] rcmd3_q;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic [7:0] shadow_val;

    // Clear control holds no state of its own and reads as zero
    assign rd_byte = hit_rcmd1 ? rcmd1_q :
                     hit_rcmd2 ? rcmd2_q :
                     hit_rcmd3 ? rcmd3_q :
                     hit_tx ? 8'(tx_cnt) :
                     hit_rx ? 8'(rx_cnt) :
                     hit_shadow ? shadow_val : `ORS_BYTE_RST;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= setup_ph;
            pslverr_q <= setup_ph & ~mapped;
            if (setup_ph)
                prdata_q <= {24'h00_0000, rd_byte};
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Remote command registers

    // Capability bits [5:4] are read-only and keep their reset value
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rcmd1_q <= `ORS_RCMD1_RST;
            rcmd2_q <= `ORS_BYTE_RST;
            rcmd3_q <= `ORS_BYTE_RST;
        end
        else if (wr_en)
        begin
            if (hit_rcmd1)
                rcmd1_q <= (pwdata[7:0] & `ORS_RCMD1_WMASK) | (rcmd1_q & ~`ORS_RCMD1_WMASK);
            if (hit_rcmd2)
                rcmd2_q <= pwdata[7:0];
            if (hit_rcmd3)
                rcmd3_q <= pwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame byte selection

    logic ext_mode;
    logic ext_sel;
    ors_pkg::ors_opcode_t opcode_sel;
    logic [7:0] data_sel;
    logic [7:0] addr_sel;
    logic frame_load_q;
    logic frame_ext_q;
    logic [1:0] frame_opc_q;
    logic [7:0] frame_data_q;
    logic [7:0] frame_addr_q;

    // Reserved mode codes behave as normal mode
    assign ext_mode = rcmd1_q[`ORS_MODE_MSB:`ORS_MODE_LSB] == `ORS_MODE_EXTENDED;
    assign ext_sel = side_q & ext_mode;
    assign opcode_sel = ext_sel ? ors_pkg::ors_opcode_t'(rcmd1_q[`ORS_OPC_MSB:`ORS_OPC_LSB]) :
                                  ors_pkg::ors_op_read_reply;
    assign data_sel = ext_sel ? rcmd3_q : model_info_data;
    assign addr_sel = ext_sel ? rcmd2_q : model_info_addr;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_load_q <= 1'b0;
            frame_ext_q <= 1'b0;
            frame_opc_q <= 2'h0;
            frame_data_q <= `ORS_BYTE_RST;
            frame_addr_q <= `ORS_BYTE_RST;
        end
        else
        begin
            frame_load_q <= cmd_issue;
            if (cmd_issue)
            begin
                frame_ext_q <= ext_sel;
                frame_opc_q <= opcode_sel;
                frame_data_q <= data_sel;
                frame_addr_q <= addr_sel;
            end
        end
    end

    assign frame_load = frame_load_q;
    assign frame_extended = frame_ext_q;
    assign frame_opcode = frame_opc_q;
    assign frame_data_byte_bits = frame_data_q;
    assign frame_address_byte = frame_addr_q;
    assign central_office_side_mode = side_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Counters and partner status copy

    logic cnt_clr;
    logic rx_inc;
    logic host_rd_shadow;

    assign cnt_clr = wr_en & hit_clr & (pwdata[7:0] == `ORS_CNT_CLR_VALUE);
    assign rx_inc = rx_pkt_done & rx_crc_good & rx_opcode_good & rx_dir_good;
    assign host_rd_shadow = access_done & ~pwrite & hit_shadow;

    ors_pkt_counter #(.WIDTH(CNT_W)) u_tx_cnt (
        .clk(pclk),
        .rst_n(presetn),
        .inc(tx_pkt_valid),
        .clr(cnt_clr),
        .count(tx_cnt)
    );

    ors_pkt_counter #(.WIDTH(CNT_W)) u_rx_cnt (
        .clk(pclk),
        .rst_n(presetn),
        .inc(rx_inc),
        .clr(cnt_clr),
        .count(rx_cnt)
    );

    ors_shadow u_shadow (
        .clk(pclk),
        .rst_n(presetn),
        .init(init_pulse),
        .center_side(sync2_q[0]),
        .link_up(optical_link),
        .partner_status(partner_status),
        .warm_event(warm_event),
        .host_read(host_rd_shadow),
        .partner_status_copy(shadow_val)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_frame_data;
        cmd_issue |=> frame_load_q && frame_data_q == $past(data_sel) && frame_ext_q == $past(ext_sel);
    endproperty
    a_frame_data: assert property (p_frame_data) else $error("frame data byte wrong source");

    property p_ext_data;
        frame_load_q && frame_ext_q |-> frame_data_q == $past(rcmd3_q);
    endproperty
    a_ext_data: assert property (p_ext_data) else $error("extended data byte not from register");

    property p_tx_inc;
        tx_pkt_valid && !cnt_clr |=> tx_cnt == CNT_W'($past(tx_cnt) + CNT_W'(1));
    endproperty
    a_tx_inc: assert property (p_tx_inc) else $error("sent count did not step");

    property p_clear;
        cnt_clr && !tx_pkt_valid && !rx_inc |=> tx_cnt == '0 && rx_cnt == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("counters not cleared");

    property p_rx_gate;
        rx_pkt_done && !(rx_crc_good && rx_opcode_good && rx_dir_good) && !cnt_clr |=> $stable(rx_cnt);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("bad packet counted");

    property p_rx_inc;
        rx_inc && !cnt_clr |=> rx_cnt == CNT_W'($past(rx_cnt) + CNT_W'(1));
    endproperty
    a_rx_inc: assert property (p_rx_inc) else $error("received count did not step");

    property p_mode_ext;
        frame_load_q && frame_ext_q |-> $past(rcmd1_q[`ORS_MODE_MSB:`ORS_MODE_LSB]) == `ORS_MODE_EXTENDED;
    endproperty
    a_mode_ext: assert property (p_mode_ext) else $error("extended frame without extended mode");

    property p_opcode;
        frame_load_q |-> frame_opcode == (frame_ext_q ? $past(rcmd1_q[`ORS_OPC_MSB:`ORS_OPC_LSB]) : 2'h0);
    endproperty
    a_opcode: assert property (p_opcode) else $error("frame opcode wrong");

    property p_addr;
        frame_load_q && frame_ext_q |-> frame_addr_q == $past(rcmd2_q);
    endproperty
    a_addr: assert property (p_addr) else $error("frame address byte wrong");

    property p_ro_write;
        wr_en && hit_tx && !tx_pkt_valid |=> $stable(tx_cnt);
    endproperty
    a_ro_write: assert property (p_ro_write) else $error("write changed sent count");

    property p_answer;
        setup_ph |=> pready_q ##1 !pready_q;
    endproperty
    a_answer: assert property (p_answer) else $error("ready not a single access cycle");

    c_ext_frame: cover property (frame_load_q && frame_ext_q);
    c_clear_read: cover property (cnt_clr ##[1:20] access_done && hit_tx && !pwrite);
    c_err: cover property (access_done && pslverr_q);

endmodule // ors_regs
`default_nettype wire

/* ors_shadow.sv */
// Purpose: Copy of the link partner status, with retention across warm reset on the central office side
// Assumes: Inputs are synchronous to clk; init pulses once after power-on reset
// Notes: The retained value is held after link return until software reads it once
`timescale 1ns/1ps
`default_nettype none
`include "ors_cfg.svh"

module ors_shadow (
    input wire logic clk,                 // Register clock
    input wire logic rst_n,               // Power-on reset, active low
    input wire logic init,                // Strap captured, one-cycle pulse
    input wire logic center_side,         // Central office side mode
    input wire logic link_up,             // Optical link up, level
    input wire logic [7:0] partner_status, // Partner status register value
    input wire logic warm_event,          // Warm reset or power down, level
    input wire logic host_read,           // Host read of the copy completes
    output logic [7:0] partner_status_copy // Shadow value
);

    ors_pkg::ors_shd_state_t state_q;
    ors_pkg::ors_shd_state_t state_d;
    logic [7:0] shadow_q;
    logic [7:0] shadow_d;

    always_comb
    begin
        state_d = state_q;
        shadow_d = shadow_q;
        case (state_q)
            ors_pkg::shd_boot:
            begin
                if (init)
                begin
                    shadow_d = center_side ? `ORS_SHADOW_DEF_CENTER : `ORS_SHADOW_DEF_TERMINAL;
                    state_d = ors_pkg::shd_mirror;
                end
            end
            ors_pkg::shd_mirror:
            begin
                if (warm_event && center_side)
                    state_d = ors_pkg::shd_retain;
                else if (warm_event)
                    shadow_d = `ORS_SHADOW_DEF_TERMINAL;
                else if (link_up)
                    shadow_d = partner_status;
            end
            ors_pkg::shd_retain:
            begin
                if (!warm_event && link_up)
                    state_d = ors_pkg::shd_hold;
            end
            default:
            begin
                // Software must see the pre-reset value before mirroring resumes
                if (warm_event)
                    state_d = ors_pkg::shd_retain;
                else if (host_read)
                    state_d = ors_pkg::shd_mirror;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ors_pkg::shd_boot;
            shadow_q <= `ORS_SHADOW_RST;
        end
        else
        begin
            state_q <= state_d;
            shadow_q <= shadow_d;
        end
    end

    assign partner_status_copy = shadow_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_term_mirror;
        state_q == ors_pkg::shd_mirror && !center_side && link_up && !warm_event
            |=> shadow_q == $past(partner_status);
    endproperty
    a_term_mirror: assert property (p_term_mirror) else $error("customer side copy not mirroring");

    property p_center_mirror;
        state_q == ors_pkg::shd_mirror && center_side && link_up && !warm_event
            |=> shadow_q == $past(partner_status);
    endproperty
    a_center_mirror: assert property (p_center_mirror) else $error("central side copy not mirroring");

    property p_center_retain;
        center_side && warm_event && state_q != ors_pkg::shd_boot |=> $stable(shadow_q) [*2];
    endproperty
    a_center_retain: assert property (p_center_retain) else $error("copy lost during warm reset");

    property p_hold_until_read;
        state_q == ors_pkg::shd_hold && !host_read && !warm_event |=> $stable(shadow_q);
    endproperty
    a_hold_until_read: assert property (p_hold_until_read) else $error("retained copy overwritten");

endmodule // ors_shadow
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the OAM maintenance register group
// Assumes: APB answers with pready; far end modelled by ors_far_end
// Notes: Pins pass synchronisers, so waits after pin changes are generous
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    typedef struct packed {logic [11:0] a; logic [7:0] w; logic [7:0] e; logic s;} ors_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, side_strap_pin = 0;
    logic warm_reset_pin = 0, power_down_pin = 0, cmd_issue = 0, tx_pkt_valid = 0, pslverr, pready;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [3:0] pstrb = 4'hF;
    logic [7:0] model_info_data = 8'h9D, model_info_addr = 8'h61, partner_status, fd, fa;
    logic [2:0] goods;
    logic [1:0] fo;
    logic optical_link_pin, rx_pkt_done, fl, fx, cs, e;
    int err_total = 0, samples_checked = 0, loads = 0;
    ors_row_t rows [8] = '{{12'h130, 8'hA5, 8'hA5, 1'b0}, {12'h12C, 8'hC3, 8'hC3, 1'b0},
        {12'h134, 8'h55, 8'h00, 1'b0}, {12'h138, 8'h55, 8'h00, 1'b0}, {12'h13C, 8'h55, 8'h07, 1'b0},
        {12'h110, 8'h01, 8'h00, 1'b0}, {12'h200, 8'h12, 8'h00, 1'b1}, {12'h128, 8'h0E, 8'h2E, 1'b0}};
    logic [7:0] st [3] = '{8'h91, 8'h33, 8'h77};

    always #10 pclk = ~pclk;
    ors_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .side_strap_pin, .optical_link_pin, .warm_reset_pin,
        .power_down_pin, .partner_status, .model_info_data, .model_info_addr, .cmd_issue, .tx_pkt_valid,
        .rx_pkt_done, .rx_crc_good(goods[2]), .rx_opcode_good(goods[1]), .rx_dir_good(goods[0]),
        .frame_load(fl), .frame_data_byte_bits(fd), .frame_address_byte(fa), .frame_opcode(fo),
        .frame_extended(fx), .central_office_side_mode(cs));
    ors_far_end far (.clk(pclk), .link_up(optical_link_pin), .status(partner_status),
        .rx_done(rx_pkt_done), .goods(goods));
    // Every frame build must show exactly one load pulse
    always @(posedge pclk)
        if (fl) loads++;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
            err_total++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x);
        apb(1'b0, a, 8'h00);
        chk("read", r, {24'h0, x});
    endtask
    task automatic rst(input logic strap);
        presetn <= 1'b0;
        side_strap_pin <= strap;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
    endtask
    task automatic hold(input logic t, input int n);
        @(posedge pclk);
        if (t)
            tx_pkt_valid <= 1'b1;
        else
            cmd_issue <= 1'b1;
        repeat (n) @(posedge pclk);
        tx_pkt_valid <= 1'b0;
        cmd_issue <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst(1'b0);
        chk("side", {31'h0, cs}, 32'h0);
        rd(12'h13C, 8'h07);
        rd(12'h134, 8'h00);
        rd(12'h138, 8'h00);
        foreach (rows[i])
        begin
            apb(1'b1, rows[i].a, rows[i].w);
            chk("error", {15'h0, e}, {15'h0, rows[i].s});
            apb(1'b0, rows[i].a, 8'h00);
            if (!rows[i].s) chk("row", r, {24'h0, rows[i].e});
        end
        hold(1'b1, 3);
        far.send(3'h7);
        far.send(3'h7);
        far.send(3'h6);
        far.send(3'h5);
        far.send(3'h3);
        rd(12'h134, 8'h03);
        rd(12'h138, 8'h02);
        hold(1'b1, 252);
        rd(12'h134, 8'hFF);
        hold(1'b1, 1);
        rd(12'h134, 8'h00);
        hold(1'b1, 2);
        apb(1'b1, 12'h110, 8'h01);
        rd(12'h138, 8'h02);
        apb(1'b1, 12'h110, 8'h00);
        rd(12'h138, 8'h00);
        rd(12'h134, 8'h00);
        far.set_link(1'b1, 8'h5E);
        repeat (6) @(posedge pclk);
        rd(12'h13C, 8'h5E);
        hold(1'b0, 1);
        chk("frame", {5'h0, fx, fo, fd}, 16'h009D);
        // Central side: strap is only taken after a fresh reset
        rst(1'b1);
        chk("side", {31'h0, cs}, 32'h1);
        rd(12'h13C, 8'h5E);
        apb(1'b1, 12'h130, 8'h5A);
        // A write with its low strobe off must leave the data byte alone
        pstrb <= 4'hE;
        apb(1'b1, 12'h130, 8'hFF);
        pstrb <= 4'hF;
        apb(1'b1, 12'h12C, 8'h3C);
        model_info_data <= 8'h6B;
        model_info_addr <= 8'h16;
        for (int i = 0; i < 16; i++)
        begin
            apb(1'b1, 12'h128, i[7:0]);
            hold(1'b0, 1);
            if (i[1:0] == 2'h2) chk("frame", {5'h0, fx, fo, fd, fa}, {6'h1, i[3:2], 8'h5A, 8'h3C});
            else chk("frame", {5'h0, fx, fo, fd, fa}, {8'h00, 8'h6B, 8'h16});
        end
        far.set_link(1'b1, st[0]);
        repeat (6) @(posedge pclk);
        rd(12'h13C, st[0]);
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0) warm_reset_pin <= 1'b1;
            else power_down_pin <= 1'b1;
            repeat (6) @(posedge pclk);
            far.set_link(1'b1, st[k+1]);
            repeat (6) @(posedge pclk);
            warm_reset_pin <= 1'b0;
            power_down_pin <= 1'b0;
            repeat (6) @(posedge pclk);
            rd(12'h13C, st[k]);
            repeat (3) @(posedge pclk);
            rd(12'h13C, st[k+1]);
        end
        chk("loads", loads, 32'd17);
        wrap_up();
    end
    // Whole run is near 700 cycles; this leaves a wide margin
    initial
    begin
        #1ms;
        err_total++;
        wrap_up();
    end
endmodule // tb_top

`default_nettype wire
